// file: core/pabm_pkg.sv
`default_nettype none
package pabm_pkg;
    // port width and pin positions
    localparam int PORT_W = 8;
    localparam int SEGMENT_LO = 4;      // segment lines on upper nibble
    localparam int COMMON_NUM = 4;      // common lines on lower nibble
    localparam int PB_MISO = 3;
    localparam int PB_MOSI = 2;
    localparam int PB_SCK = 1;
    localparam int PB_SS = 0;
    localparam int PB_TMR2_CMP_A = 7;
    localparam int PB_TMR1_CMP_B = 6;
    localparam int PB_TMR1_CMP_A = 5;
    localparam int PB_TMR0_CMP_A = 4;
    // multiplex setting codes: commons in use beyond common line 0
    localparam logic [1:0] MUX_COMMON1 = 2'h1;
    localparam logic [1:0] MUX_COMMON2 = 2'h2;
    localparam logic [1:0] MUX_COMMON3 = 2'h3;
    localparam logic [7:0] ALL_ZERO = 8'h00;
endpackage
`default_nettype wire

// file: core/pabm_pin_ctrl.sv
`default_nettype none
// ----------------------------------------
// generic pin attribute resolution
// ----------------------------------------
module pabm_pin_ctrl #(
    parameter int W = 8
) (
    input wire logic [W-1:0] dir_reg,
    input wire logic [W-1:0] out_reg,
    input wire logic pullup_disable,
    input wire logic sleep_clamp,
    input wire logic [W-1:0] pullup_override_en,
    input wire logic [W-1:0] pullup_override_val,
    input wire logic [W-1:0] direction_override_en,
    input wire logic [W-1:0] direction_override_val,
    input wire logic [W-1:0] value_override_en,
    input wire logic [W-1:0] value_override_val,
    input wire logic [W-1:0] input_enable_override_en,
    input wire logic [W-1:0] input_enable_override_val,
    output logic [W-1:0] pad_pullup,
    output logic [W-1:0] pad_drive_en,
    output logic [W-1:0] pad_drive_val,
    output logic [W-1:0] pad_input_en
);
    // each enable hands its attribute to the override value
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            pad_pullup[i] = pullup_override_en[i] ? pullup_override_val[i]
                : (!dir_reg[i] && out_reg[i] && !pullup_disable);
            pad_drive_en[i] = direction_override_en[i]
                ? direction_override_val[i] : dir_reg[i];
            pad_drive_val[i] = value_override_en[i]
                ? value_override_val[i] : out_reg[i];
            pad_input_en[i] = input_enable_override_en[i]
                ? input_enable_override_val[i] : !sleep_clamp;
        end
    end
endmodule
`default_nettype wire

// file: core/pabm_mux.sv
`default_nettype none
module pabm_mux #(
    parameter int W = pabm_pkg::PORT_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic lcd_enable,
    input wire logic [1:0] lcd_multiplex_select,
    input wire logic [3:0] lcd_segment_drive,
    input wire logic [3:0] common_line,
    input wire logic spi_enable,
    input wire logic spi_master,
    input wire logic spi_slave_out,
    input wire logic spi_master_out,
    input wire logic spi_sck_out,
    input wire logic timer2_compare_a_en,
    input wire logic timer2_compare_a_out,
    input wire logic timer1_compare_b_en,
    input wire logic timer1_compare_b_out,
    input wire logic timer1_compare_a_en,
    input wire logic timer1_compare_a_out,
    input wire logic timer0_compare_a_en,
    input wire logic timer0_compare_a_out,
    input wire logic pin_change_en,
    input wire logic pullup_disable,
    input wire logic sleep_clamp,
    input wire logic [W-1:0] porta_dir,
    input wire logic [W-1:0] porta_out,
    input wire logic [W-1:0] portb_dir,
    input wire logic [W-1:0] portb_out,
    input wire logic [W-1:0] portb_raw_pin_input,
    output logic [W-1:0] porta_pullup,
    output logic [W-1:0] porta_drive_en,
    output logic [W-1:0] porta_drive_val,
    output logic [W-1:0] porta_input_en,
    output logic [W-1:0] porta_analog_en,
    output logic [W-1:0] porta_analog_pad_link,
    output logic [W-1:0] portb_pullup,
    output logic [W-1:0] portb_drive_en,
    output logic [W-1:0] portb_drive_val,
    output logic [W-1:0] portb_input_en,
    output logic [15:8] pin_change_source,
    output logic spi_miso_in,
    output logic spi_mosi_in,
    output logic spi_sck_in,
    output logic spi_slave_select_n
);
    // ----------------------------------------
    // state (one unused bit only; outputs are a pure override network)
    // ----------------------------------------
    typedef struct packed {
        logic unused_bit;
    } pabm_state_t;
    pabm_state_t st_q;
    pabm_state_t st_d;

    // keep the housekeeping flop trivially defined after reset
    always_comb
    begin
        st_d = st_q;
        st_d.unused_bit = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // ----------------------------------------
    // port a: lcd overrides
    // ----------------------------------------
    logic [W-1:0] a_ovr;
    logic [3:0] common_used;

    always_comb
    begin
        common_used[0] = 1'b1;
        common_used[1] = lcd_multiplex_select >= pabm_pkg::MUX_COMMON1;
        common_used[2] = lcd_multiplex_select >= pabm_pkg::MUX_COMMON2;
        common_used[3] = lcd_multiplex_select >= pabm_pkg::MUX_COMMON3;
    end

    assign a_ovr[W-1:pabm_pkg::SEGMENT_LO] = {4{lcd_enable}};
    assign a_ovr[pabm_pkg::COMMON_NUM-1:0] = {4{lcd_enable}} & common_used;

    // segment and common wiring onto the analog link
    assign porta_analog_pad_link = {lcd_segment_drive, common_line};
    assign porta_analog_en = a_ovr;

    // port a resolution; values all zero, port value never overridden
    pabm_pin_ctrl #(.W(W)) u_pa (
        .dir_reg(porta_dir),
        .out_reg(porta_out),
        .pullup_disable(pullup_disable),
        .sleep_clamp(sleep_clamp),
        .pullup_override_en(a_ovr),
        .pullup_override_val(pabm_pkg::ALL_ZERO),
        .direction_override_en(a_ovr),
        .direction_override_val(pabm_pkg::ALL_ZERO),
        .value_override_en(pabm_pkg::ALL_ZERO),
        .value_override_val(pabm_pkg::ALL_ZERO),
        .input_enable_override_en(a_ovr),
        .input_enable_override_val(pabm_pkg::ALL_ZERO),
        .pad_pullup(porta_pullup),
        .pad_drive_en(porta_drive_en),
        .pad_drive_val(porta_drive_val),
        .pad_input_en(porta_input_en)
    );

    // ----------------------------------------
    // port b: timers, spi, pin change
    // ----------------------------------------
    logic spi_mst;
    logic spi_slv;
    logic [W-1:0] b_pu_en, b_pu_val, b_dd_en, b_pv_en, b_pv_val;
    logic [W-1:0] b_ie_en;

    assign spi_mst = spi_enable & spi_master;
    assign spi_slv = spi_enable & ~spi_master;

    always_comb
    begin
        b_pu_en = '0;
        b_pu_val = '0;
        b_dd_en = '0;
        b_pv_en = '0;
        b_pv_val = '0;
        // timer compare outputs; driver stays under dir bit
        b_pv_en[pabm_pkg::PB_TMR2_CMP_A] = timer2_compare_a_en;
        b_pv_val[pabm_pkg::PB_TMR2_CMP_A] = timer2_compare_a_out;
        b_pv_en[pabm_pkg::PB_TMR1_CMP_B] = timer1_compare_b_en;
        b_pv_val[pabm_pkg::PB_TMR1_CMP_B] = timer1_compare_b_out;
        b_pv_en[pabm_pkg::PB_TMR1_CMP_A] = timer1_compare_a_en;
        b_pv_val[pabm_pkg::PB_TMR1_CMP_A] = timer1_compare_a_out;
        b_pv_en[pabm_pkg::PB_TMR0_CMP_A] = timer0_compare_a_en;
        b_pv_val[pabm_pkg::PB_TMR0_CMP_A] = timer0_compare_a_out;
        // miso forced input only as master
        b_dd_en[pabm_pkg::PB_MISO] = spi_mst;
        // mosi forced input only as slave
        b_dd_en[pabm_pkg::PB_MOSI] = spi_slv;
        // sck forced input only as slave
        b_dd_en[pabm_pkg::PB_SCK] = spi_slv;
        // slave select forced input as slave
        b_dd_en[pabm_pkg::PB_SS] = spi_slv;
        // pull-up on forced inputs follows the output bit
        for (int i = 0; i <= pabm_pkg::PB_MISO; i++)
        begin
            b_pu_en[i] = b_dd_en[i];
            b_pu_val[i] = portb_out[i] & ~pullup_disable;
        end
        // driving spi outputs: master drives mosi, sck; slave drives miso
        b_pv_en[pabm_pkg::PB_MISO] = spi_slv;
        b_pv_val[pabm_pkg::PB_MISO] = spi_slave_out;
        b_pv_en[pabm_pkg::PB_MOSI] = spi_mst;
        b_pv_val[pabm_pkg::PB_MOSI] = spi_master_out;
        b_pv_en[pabm_pkg::PB_SCK] = spi_mst;
        b_pv_val[pabm_pkg::PB_SCK] = spi_sck_out;
        // pin change keeps the input alive through sleep
        b_ie_en = {W{pin_change_en}};
    end

    pabm_pin_ctrl #(.W(W)) u_pb (
        .dir_reg(portb_dir),
        .out_reg(portb_out),
        .pullup_disable(pullup_disable),
        .sleep_clamp(sleep_clamp),
        .pullup_override_en(b_pu_en),
        .pullup_override_val(b_pu_val),
        .direction_override_en(b_dd_en),
        .direction_override_val(pabm_pkg::ALL_ZERO),
        .value_override_en(b_pv_en),
        .value_override_val(b_pv_val),
        .input_enable_override_en(b_ie_en),
        .input_enable_override_val(b_ie_en),
        .pad_pullup(portb_pullup),
        .pad_drive_en(portb_drive_en),
        .pad_drive_val(portb_drive_val),
        .pad_input_en(portb_input_en)
    );

    // pin change sources, raw inputs (consumer synchronises)
    assign pin_change_source = portb_raw_pin_input;
    assign spi_miso_in = portb_raw_pin_input[pabm_pkg::PB_MISO];
    assign spi_mosi_in = portb_raw_pin_input[pabm_pkg::PB_MOSI];
    assign spi_sck_in = portb_raw_pin_input[pabm_pkg::PB_SCK];
    assign spi_slave_select_n = portb_raw_pin_input[pabm_pkg::PB_SS];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // segment pins released by lcd
    segment_release_a: assert property (@(posedge clk) disable iff (sys_rst)
        lcd_enable |-> (porta_drive_en[W-1:pabm_pkg::SEGMENT_LO] == '0
        && porta_pullup[W-1:pabm_pkg::SEGMENT_LO] == '0
        && porta_input_en[W-1:pabm_pkg::SEGMENT_LO] == '0))
        else $error("segment pins not released");
    // common zero override
    common_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        lcd_enable |-> !porta_drive_en[0] && porta_analog_en[0])
        else $error("common 0 not overridden");
    // common three with mux
    common_three_a: assert property (@(posedge clk) disable iff (sys_rst)
        (lcd_enable && lcd_multiplex_select != pabm_pkg::MUX_COMMON3)
        |-> porta_drive_en[3] == porta_dir[3])
        else $error("common 3 wrongly overridden");
    // miso master input
    miso_master_a: assert property (@(posedge clk) disable iff (sys_rst)
        spi_mst |-> !portb_drive_en[3]
        && portb_pullup[3] == (portb_out[3] && !pullup_disable))
        else $error("miso not forced input");
    // miso slave direction
    miso_slave_a: assert property (@(posedge clk) disable iff (sys_rst)
        spi_slv |-> portb_drive_en[3] == portb_dir[3])
        else $error("miso direction overridden");
    // mosi slave input
    mosi_slave_a: assert property (@(posedge clk) disable iff (sys_rst)
        spi_slv |-> !portb_drive_en[2] && !portb_drive_en[0])
        else $error("mosi or ss not input");
    // sck slave input
    sck_slave_a: assert property (@(posedge clk) disable iff (sys_rst)
        spi_slv |-> !portb_drive_en[1])
        else $error("sck not input");
    // plain gpio without overrides
    plain_gpio_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!lcd_enable && !spi_enable && !pin_change_en && !sleep_clamp)
        |-> porta_drive_en == porta_dir && porta_input_en == 8'hFF)
        else $error("plain pin not ordinary");
    // pin change wiring
    pin_change_a: assert property (@(posedge clk) disable iff (sys_rst)
        pin_change_source == portb_raw_pin_input)
        else $error("pin change map wrong");
endmodule
`default_nettype wire

// file: sim/pabm_periph_model.sv
`default_nettype none
// ------------------------------
// lcd, timer and spi side
// ------------------------------
module pabm_periph_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] timer_run,
    output logic [3:0] timer_en,
    output logic [3:0] timer_out,
    output logic [3:0] segment_out,
    output logic [3:0] common_out,
    output logic [2:0] spi_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wave_q;
    // odd step so bit 0 toggles each cycle; the other lines do not move every cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            wave_q <= 8'h00;
        else
            wave_q <= wave_q + 8'h35;
    end
    // compare outputs own pins 7..4 only while their timer runs
    assign timer_en = timer_run;
    assign timer_out = wave_q[3:0];
    assign segment_out = wave_q[7:4];
    assign common_out = ~wave_q[3:0];
    assign spi_out = wave_q[6:4];
endmodule
`default_nettype wire

// file: sim/pabm_mux_tb.sv
`default_nettype none
module pabm_mux_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, len, sen, sm, pce, pud, slp;
    logic [1:0] mux;
    logic [3:0] trun, ten, tout, sg, cm;
    logic [2:0] so;
    logic [7:0] adir, aout, bdir, bout, braw, apu, aden, adv, aie;
    logic [7:0] aan, alnk, bpu, bden, bdv, bie;
    logic [15:8] pcs;
    logic mi, mo, sk, ssn;
    int checks, mismatches;
    pabm_periph_model pabm_periph_model_inst (.clk(clk), .sys_rst(rst),
        .timer_run(trun), .timer_en(ten), .timer_out(tout),
        .segment_out(sg), .common_out(cm), .spi_out(so));
    pabm_mux pabm_mux_inst (.clk(clk), .sys_rst(rst), .lcd_enable(len),
        .lcd_multiplex_select(mux), .lcd_segment_drive(sg),
        .common_line(cm), .spi_enable(sen), .spi_master(sm),
        .spi_slave_out(so[0]), .spi_master_out(so[2]),
        .spi_sck_out(so[1]), .timer2_compare_a_en(ten[3]),
        .timer2_compare_a_out(tout[3]), .timer1_compare_b_en(ten[2]),
        .timer1_compare_b_out(tout[2]), .timer1_compare_a_en(ten[1]),
        .timer1_compare_a_out(tout[1]), .timer0_compare_a_en(ten[0]),
        .timer0_compare_a_out(tout[0]), .pin_change_en(pce),
        .pullup_disable(pud), .sleep_clamp(slp), .porta_dir(adir),
        .porta_out(aout), .portb_dir(bdir), .portb_out(bout),
        .portb_raw_pin_input(braw), .porta_pullup(apu),
        .porta_drive_en(aden), .porta_drive_val(adv),
        .porta_input_en(aie), .porta_analog_en(aan),
        .porta_analog_pad_link(alnk), .portb_pullup(bpu),
        .portb_drive_en(bden), .portb_drive_val(bdv),
        .portb_input_en(bie), .pin_change_source(pcs),
        .spi_miso_in(mi), .spi_mosi_in(mo), .spi_sck_in(sk),
        .spi_slave_select_n(ssn));
    // ------------------------------
    // checking helpers
    // ------------------------------
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // expected pad controls worked out from the inputs of this cycle
    task automatic check_all();
        logic [7:0] m, f, ie, pu, dv;
        m = len ? {4'hF, mux == 2'h3, mux >= 2'h2, mux >= 2'h1, 1'b1} : 8'h00;
        f = !sen ? 8'h00 : (sm ? 8'h08 : 8'h07);
        ie = slp ? 8'h00 : 8'hFF;
        pu = bout & {8{~pud}};
        dv = bout;
        for (int i = 0; i < 4; i++)
            if (ten[i])
                dv[4+i] = tout[i];
        if (sen && !sm)
            dv[3] = so[0];
        if (sen && sm)
            dv[2:1] = so[2:1];
        cmp(apu, ~adir & aout & {8{~pud}} & ~m);
        cmp(aden, adir & ~m);
        cmp(adv, aout);
        cmp(aie, ie & ~m);
        cmp(aan, m);
        cmp(alnk, {sg, cm});
        cmp(bpu, (~bdir & pu & ~f) | (f & pu));
        cmp(bden, bdir & ~f);
        cmp(bdv, dv);
        cmp(bie, pce ? 8'hFF : ie);
        cmp(pcs, braw);
        cmp({4'h0, mi, mo, sk, ssn}, {4'h0, braw[3:0]});
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // a hang cannot outlast a few hundred cycles of tests
    initial
    begin
        #8000;
        mismatches++;
        results();
    end
    // ------------------------------
    // test sequence
    // ------------------------------
    initial
    begin
        {rst, len, sen, sm, pce, pud, slp} = 7'h40;
        {mux, trun, adir, aout, bdir, bout, braw} = 46'h0;
        checks = 0;
        mismatches = 0;
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        for (int k = 0; k < 8; k++)
        begin
            @(negedge clk);
            pud = k[2];
            adir = 8'hC3 ^ (8'h11 << k);
            aout = 8'hA5 + 8'(k);
            bdir = ~adir;
            bout = ~aout;
            braw = aout;
            #2 check_all();
        end
        $display("test gpio done");
        @(negedge clk) adir = 8'hFF;
        // lcd stays on across a rising edge so the lcd assertions see it
        for (int k = 0; k < 4; k++)
        begin
            @(negedge clk);
            {len, mux} = {1'b1, 2'(k)};
            #2 check_all();
            @(negedge clk) len = 1'b0;
            #2 check_all();
        end
        $display("test lcd done");
        // direction set before the compare outputs take the pins
        @(negedge clk) bdir = 8'hF0;
        for (int k = 0; k < 4; k++)
        begin
            @(negedge clk);
            trun = 4'hF >> k;
            #2 check_all();
        end
        @(negedge clk) trun = 4'h0;
        $display("test timer done");
        for (int k = 0; k < 4; k++)
        begin
            @(negedge clk);
            {sen, sm, pud} = {1'b1, k[1], k[0]};
            {bdir, bout} = 16'hFF0E;
            #2 check_all();
        end
        @(negedge clk) sen = 1'b0;
        $display("test spi done");
        @(negedge clk) slp = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            @(negedge clk);
            pce = k[0];
            braw = 8'h81 << k;
            #2 check_all();
        end
        $display("test sleep done");
        results();
    end
endmodule
`default_nettype wire
